// File: bmc_init_model.sv
// Initiator-side model that holds each request until its completion
`timescale 1ns/1ps
module bmc_init_model (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst_b,
  // Bench commands
  input  wire logic [4:0] start,
  input  wire logic       um_sel,
  input  wire logic       ram_sel,
  // Matrix side
  input  wire logic [4:0] ack,
  output logic [4:0]      req_ff,
  output logic [4:0]      unmapped_ff,
  output logic [4:0]      ram_hit_ff
);
  // Request held until ack; idle qualifiers flip so stale ones look wrong
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      req_ff      <= 5'h00;
      unmapped_ff <= 5'h1f;
      ram_hit_ff  <= 5'h1f;
    end
    else
    begin
      for (int i = 0; i < 5; i++)
      begin
        if (start[i])
        begin
          req_ff[i]      <= 1'b1;
          unmapped_ff[i] <= um_sel;
          ram_hit_ff[i]  <= ram_sel;
        end
        else if (ack[i] && req_ff[i])
        begin
          req_ff[i]      <= 1'b0;
          unmapped_ff[i] <= ~unmapped_ff[i];
          ram_hit_ff[i]  <= ~ram_hit_ff[i];
        end
      end
    end
  end
endmodule // bmc_init_model

// File: bmc_pkg.sv
// Shared constants and types of the bus matrix configuration block
package bmc_pkg;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int NUM_INIT = 5;
  localparam int STAT_W   = 6;

  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [7:0] CFG_OFS  = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] MASK_OFS = 8'h08;
  localparam logic [7:0] LAST_OFS = 8'h0c;

  // ****************************************************************
  // Configuration fields and reset values
  // ****************************************************************
  localparam int          ERR_EN_LSB   = 16;
  localparam int          WAIT_SEL_BIT = 6;
  localparam int          ARB_LSB      = 0;
  localparam int          ARB_W        = 3;
  localparam logic [31:0] CFG_WMASK    = 32'h001f0047;
  localparam logic [31:0] CFG_RST      = 32'h001f0041;
  localparam logic [5:0]  STAT_RST     = 6'h00;
  localparam logic [5:0]  MASK_RST     = 6'h00;
  localparam int          RSV_ARB_BIT  = 5;
  localparam int          CNT_LSB      = 8;

  // ****************************************************************
  // Initiator indices
  // ****************************************************************
  localparam int INIT_FETCH  = 0;
  localparam int INIT_DATA   = 1;
  localparam int INIT_DMA    = 2;
  localparam int INIT_DEBUG  = 3;
  localparam int INIT_SHARED = 4;

  // Arbitration modes
  typedef enum logic [2:0] {
    ARB_MODE0 = 3'h0,
    ARB_MODE1 = 3'h1,
    ARB_MODE2 = 3'h2
  } bmc_arb_t;

  // Per-initiator access sequencer states
  typedef enum logic [1:0] {
    PS_IDLE  = 2'h0,
    PS_SETUP = 2'h1,
    PS_DONE  = 2'h2
  } bmc_port_st_t;

endpackage

// File: bmc_port.sv
// Access sequencer of one initiator of the bus matrix
`timescale 1ns/1ps
module bmc_port #(
  parameter bit IS_CPU = 1'b0
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst_b,
  // Initiator request side
  input  wire logic req,
  input  wire logic unmapped,
  input  wire logic ram_hit,
  // Configuration
  input  wire logic err_en,
  input  wire logic dbg_mode,
  input  wire logic wait_sel,
  // Arbiter
  input  wire logic gnt,
  output logic      want,
  // Answer side
  output logic      ack,
  output logic      berr,
  output logic      null_ack
);

  bmc_pkg::bmc_port_st_t st_ff;
  bmc_pkg::bmc_port_st_t nxt_st;
  logic                  berr_ff;
  logic                  null_ff;
  logic                  need_wait;
  logic                  idle_req;
  logic                  err_ok;

  // ****************************************************************
  // Decode
  // ****************************************************************
  // CPU fetch and data RAM accesses may need one setup cycle
  assign need_wait = IS_CPU & ram_hit & wait_sel;
  assign idle_req  = (st_ff == bmc_pkg::PS_IDLE) & req;
  // Debug mode masks CPU error reporting
  assign err_ok    = err_en & ~(IS_CPU & dbg_mode);
  assign want      = req & ~unmapped &
                     ((st_ff == bmc_pkg::PS_SETUP) |
                      (idle_req & ~need_wait));
  assign ack       = (st_ff == bmc_pkg::PS_DONE);
  assign berr      = berr_ff;
  assign null_ack  = null_ff;

  // Next state; an unmapped access never waits on the arbiter
  always_comb
  begin
    nxt_st = st_ff;
    unique case (st_ff)
      bmc_pkg::PS_IDLE:
      begin
        if (idle_req & unmapped)
          nxt_st = bmc_pkg::PS_DONE;
        else if (idle_req & need_wait)
          nxt_st = bmc_pkg::PS_SETUP;
        else if (want & gnt)
          nxt_st = bmc_pkg::PS_DONE;
      end
      bmc_pkg::PS_SETUP:
      begin
        if (!req)
          nxt_st = bmc_pkg::PS_IDLE;
        else if (gnt)
          nxt_st = bmc_pkg::PS_DONE;
      end
      bmc_pkg::PS_DONE:
        nxt_st = bmc_pkg::PS_IDLE;
      default:
        nxt_st = bmc_pkg::PS_IDLE;
    endcase
  end

  // State and answer flags
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_ff   <= bmc_pkg::PS_IDLE;
      berr_ff <= 1'b0;
      null_ff <= 1'b0;
    end
    else
    begin
      st_ff   <= nxt_st;
      berr_ff <= idle_req & unmapped & err_ok;
      null_ff <= idle_req & unmapped;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  unmapped_done_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    idle_req && unmapped |=> ack && null_ack)
    else $error("unmapped access not completed next cycle");

  setup_wait_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    idle_req && !unmapped && need_wait |=> !ack ##1 1'b1)
    else $error("setup wait state skipped");

endmodule // bmc_port

// File: bmc_tb.sv
// Self-checking bench of the bus matrix configuration block
`timescale 1ns/1ps
module tb;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic        clock;
  logic        rst_b;
  logic        ext_b;
  logic        dev_rst_b;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic [4:0]  start;
  logic        um_sel;
  logic        ram_sel;
  logic        dbg;
  logic [4:0]  req;
  logic [4:0]  unmapped;
  logic [4:0]  ram_hit;
  logic [4:0]  ack;
  logic [4:0]  berr;
  logic [4:0]  nul;
  logic [2:0]  arb_mode;
  logic        wsel;
  logic        irq;
  int          miscompares;
  int          total_checks;
  int          n;
  logic        b;
  logic        nl;

  bmc_top #(.ADDR_W(8)) uut (
    .clock(clock), .rst_b(rst_b), .external_reset_pin_b(ext_b),
    .dev_rst_b(dev_rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .init_req(req), .init_unmapped(unmapped), .init_ram_hit(ram_hit),
    .cpu_debug_mode(dbg), .init_ack(ack), .init_berr(berr),
    .init_null(nul), .arb_mode(arb_mode),
    .ram_wait_state_select(wsel), .irq(irq));

  bmc_init_model model (
    .clock(clock), .rst_b(rst_b), .start(start), .um_sel(um_sel),
    .ram_sel(ram_sel), .ack(ack), .req_ff(req),
    .unmapped_ff(unmapped), .ram_hit_ff(ram_hit));

  // 250 MHz clock
  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic finish_test;
    $display("Checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    check(reg_rdata, exp);
  endtask

  // Fetch and DMA request together; the grant order shows the mode
  task automatic race(input logic [2:0] m, input logic [4:0] first,
                      input logic [4:0] second);
    wr(bmc_pkg::CFG_OFS, {29'h0, m});
    @(posedge clock);
    start   <= 5'h05;
    um_sel  <= 1'b0;
    ram_sel <= 1'b0;
    @(posedge clock);
    start <= 5'h00;
    @(posedge clock);
    #1;
    check(ack, first);
    @(posedge clock);
    #1;
    check(ack, second);
  endtask

  // One access; n counts cycles from request to completion
  task automatic acc(input int i, input logic um, input logic rh);
    @(posedge clock);
    start   <= 5'h01 << i;
    um_sel  <= um;
    ram_sel <= rh;
    @(posedge clock);
    start <= 5'h00;
    #1;
    n = 0;
    while (n < 20 && ack[i] !== 1'b1)
    begin
      @(posedge clock);
      #1;
      n++;
    end
    if (n == 20)
    begin
      miscompares++;
      $display("MISMATCH at %0t: no completion", $time);
      finish_test();
    end
    b  = berr[i];
    nl = nul[i];
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    miscompares  = 0;
    total_checks = 0;
    rst_b     = 1'b0;
    ext_b     = 1'b1;
    reg_addr  = 8'h00;
    reg_wdata = 32'h00000000;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    start     = 5'h00;
    um_sel    = 1'b0;
    ram_sel   = 1'b0;
    dbg       = 1'b0;
    repeat (16) @(posedge clock);
    rst_b <= 1'b1;
    repeat (4) @(posedge clock);
    rdc(bmc_pkg::CFG_OFS, 32'h001f0041);
    check(arb_mode, 32'h1);
    check(wsel, 32'h1);
    check(irq, 32'h0);
    $display("Test reset values done");

    wr(bmc_pkg::CFG_OFS, 32'hffffffff);
    rdc(bmc_pkg::CFG_OFS, 32'h001f0047);
    rdc(bmc_pkg::STAT_OFS, 32'h20);
    wr(bmc_pkg::CFG_OFS, 32'hffe0ffb8);
    rdc(bmc_pkg::CFG_OFS, 32'h00000000);
    check(wsel, 32'h0);
    for (int c = 0; c < 3; c++)
    begin
      wr(bmc_pkg::CFG_OFS, c);
      rdc(bmc_pkg::CFG_OFS, c);
      check(arb_mode, c);
    end
    $display("Test configuration fields done");

    for (int i = 0; i < 5; i++)
    begin
      wr(bmc_pkg::CFG_OFS, 32'h1 << (16 + i));
      acc(i, 1'b1, 1'b0);
      check(n, 1);
      check(b, 1);
      check(nl, 1);
      wr(bmc_pkg::CFG_OFS, 32'h0);
      acc(i, 1'b1, 1'b0);
      check(b, 0);
      check(nl, 1);
    end
    @(posedge clock);
    dbg <= 1'b1;
    wr(bmc_pkg::CFG_OFS, 32'h001f0000);
    for (int i = 0; i < 3; i++)
    begin
      acc(i, 1'b1, 1'b0);
      check(b, i == 2);
    end
    @(posedge clock);
    dbg <= 1'b0;
    $display("Test error enables done");

    // Setup cycle only for the two CPU initiators
    wr(bmc_pkg::CFG_OFS, 32'h40);
    for (int i = 0; i < 3; i++)
    begin
      acc(i, 1'b0, 1'b1);
      check(n, (i < 2) ? 2 : 1);
      check(nl, 0);
    end
    wr(bmc_pkg::CFG_OFS, 32'h0);
    acc(1, 1'b0, 1'b1);
    check(n, 1);
    $display("Test wait states done");

    // Mode 2 leaves fetch as last winner, so mode 1 must start at data
    race(3'h2, 5'h04, 5'h01);
    race(3'h1, 5'h04, 5'h01);
    race(3'h0, 5'h01, 5'h04);
    $display("Test arbitration done");

    wr(bmc_pkg::STAT_OFS, 32'h3f);
    rdc(bmc_pkg::STAT_OFS, 32'h0);
    wr(bmc_pkg::MASK_OFS, 32'h04);
    wr(bmc_pkg::CFG_OFS, 32'h001f0000);
    acc(3, 1'b1, 1'b0);
    repeat (2) @(posedge clock);
    #1;
    check(irq, 32'h0);
    acc(2, 1'b1, 1'b0);
    repeat (2) @(posedge clock);
    #1;
    check(irq, 32'h1);
    wr(bmc_pkg::STAT_OFS, 32'h04);
    rdc(bmc_pkg::STAT_OFS, 32'h08);
    check(irq, 32'h0);
    // Eight bus errors so far, the last one from the DMA
    rdc(bmc_pkg::LAST_OFS, 32'h00000802);
    wr(8'h10, 32'hffffffff);
    rdc(8'h10, 32'h0);
    $display("Test interrupt done");

    // Pin reset in mid-run must restore the configuration
    @(posedge clock);
    ext_b <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
    check(dev_rst_b, 32'h0);
    @(posedge clock);
    ext_b <= 1'b1;
    repeat (4) @(posedge clock);
    check(dev_rst_b, 32'h1);
    rdc(bmc_pkg::CFG_OFS, 32'h001f0041);
    rdc(bmc_pkg::MASK_OFS, 32'h0);
    rdc(bmc_pkg::STAT_OFS, 32'h0);
    $display("Test pin reset done");
    finish_test();
  end
endmodule // tb

// File: bmc_top.sv
// Bus matrix configuration, error reporting and arbitration
//
// Overview of operation
// - External reset pin low resets the device; it is the hardware reset.
// - Shared-bus unmapped access raises bus error only when its enable is 1.
// - Debug-unit unmapped access raises bus error only when its enable is 1.
// - DMA unmapped access raises bus error only when its enable is 1.
// - CPU data unmapped access errors when enabled, never in debug mode.
// - CPU fetch unmapped access errors when enabled, never in debug mode.
// - Wait select 1 adds one setup cycle on CPU RAM access; resets to 1.
// - Arbitration field: 000 mode 0, 001 mode 1 default, 010 mode 2.
// - Unimplemented configuration bits read zero and ignore writes.
`timescale 1ns/1ps
module bmc_top #(
  parameter int ADDR_W = 8
) (
  // Clock and resets
  input  wire logic              clock,
  input  wire logic              rst_b,
  input  wire logic              external_reset_pin_b,
  output logic                   dev_rst_b,
  // Register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [31:0]            reg_rdata,
  // Initiator requests, bit index is the initiator
  input  wire logic [4:0]        init_req,
  input  wire logic [4:0]        init_unmapped,
  input  wire logic [4:0]        init_ram_hit,
  input  wire logic              cpu_debug_mode,
  // Initiator answers
  output logic [4:0]             init_ack,
  output logic [4:0]             init_berr,
  output logic [4:0]             init_null,
  // Matrix controls
  output logic [2:0]             arb_mode,
  output logic                   ram_wait_state_select,
  output logic                   irq
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  localparam int N = bmc_pkg::NUM_INIT;

  logic              sync1_ff;
  logic              sync2_ff;
  logic              pin_rst_b;
  logic [31:0]       cfg_ff;
  logic [31:0]       nxt_cfg;
  logic [5:0]        stat_ff;
  logic [5:0]        nxt_stat;
  logic [5:0]        mask_ff;
  logic [2:0]        last_id_ff;
  logic [7:0]        err_cnt_ff;
  logic [7:0]        nxt_cnt;
  logic [31:0]       rdata_ff;
  logic [31:0]       rd_mux;
  logic [2:0]        rr_last_ff;
  logic [2:0]        arb_start;
  logic [N-1:0]      want;
  logic [N-1:0]      gnt;
  logic [N-1:0]      err_en;
  logic [5:0]        events;
  logic              sel_cfg;
  logic              sel_stat;
  logic              sel_mask;
  logic              sel_last;
  logic              rsv_wr;

  // Parameter sanity
  if (ADDR_W < 4)
    $error("ADDR_W too small for the register map");

  // ****************************************************************
  // Functions
  // ****************************************************************
  // Modulo-5 increment, used for round robin and search order
  function automatic logic [2:0] inc5(input logic [2:0] v);
    inc5 = (v == 3'h4) ? 3'h0 : 3'(v + 3'h1);
  endfunction

  // First requester found scanning upward from start, wrapping
  function automatic logic [4:0] pick(input logic [4:0] r,
                                      input logic [2:0] start);
    logic [2:0] idx;
    logic [4:0] res;
    idx = start;
    res = 5'h00;
    for (int i = 0; i < 5; i++)
    begin
      if (res == 5'h00 && r[idx])
        res[idx] = 1'b1;
      idx = inc5(idx);
    end
    pick = res;
  endfunction

  // Index of the single set bit of a one-hot vector
  function automatic logic [2:0] idx_of(input logic [4:0] oh);
    logic [2:0] res;
    res = 3'h0;
    for (int i = 0; i < 5; i++)
      if (oh[i])
        res = 3'(i);
    idx_of = res;
  endfunction

  // ****************************************************************
  // Reset
  // ****************************************************************
  // Pin low asserts at once; release is synchronised to the clock
  assign pin_rst_b = rst_b & external_reset_pin_b;

  always_ff @(posedge clock or negedge pin_rst_b)
  begin
    if (!pin_rst_b)
    begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
    end
    else
    begin
      sync1_ff <= 1'b1;
      sync2_ff <= sync1_ff;
    end
  end

  assign dev_rst_b = sync2_ff;

  // ****************************************************************
  // Register decode
  // ****************************************************************
  assign sel_cfg  = (reg_addr == ADDR_W'(bmc_pkg::CFG_OFS));
  assign sel_stat = (reg_addr == ADDR_W'(bmc_pkg::STAT_OFS));
  assign sel_mask = (reg_addr == ADDR_W'(bmc_pkg::MASK_OFS));
  assign sel_last = (reg_addr == ADDR_W'(bmc_pkg::LAST_OFS));

  // Only implemented bits take write data
  assign nxt_cfg = reg_wr & sel_cfg
                 ? (reg_wdata & bmc_pkg::CFG_WMASK)
                 : cfg_ff;

  // Reserved codes are kept but flagged, so software notices
  assign rsv_wr = reg_wr & sel_cfg &
                  (reg_wdata[bmc_pkg::ARB_LSB +: 3] > 3'h2);

  assign err_en = cfg_ff[bmc_pkg::ERR_EN_LSB +: 5];
  assign events = {rsv_wr, init_berr};

  // A new event wins over a write-one clear in the same cycle
  assign nxt_stat = (stat_ff & ~(reg_wr & sel_stat
                                 ? reg_wdata[5:0] : 6'h00)) | events;

  // Error count saturates rather than wrapping
  assign nxt_cnt = (|init_berr && err_cnt_ff != 8'hff)
                 ? 8'(err_cnt_ff + 8'h01) : err_cnt_ff;

  assign rd_mux = sel_cfg  ? cfg_ff
                : sel_stat ? {26'h0, stat_ff}
                : sel_mask ? {26'h0, mask_ff}
                : sel_last ? {16'h0, err_cnt_ff, 5'h00, last_id_ff}
                : 32'h0;

  // Configuration and interrupt registers
  always_ff @(posedge clock or negedge sync2_ff)
  begin
    if (!sync2_ff)
    begin
      cfg_ff  <= bmc_pkg::CFG_RST;
      stat_ff <= bmc_pkg::STAT_RST;
      mask_ff <= bmc_pkg::MASK_RST;
    end
    else
    begin
      cfg_ff  <= nxt_cfg;
      stat_ff <= nxt_stat;
      mask_ff <= (reg_wr & sel_mask) ? reg_wdata[5:0] : mask_ff;
    end
  end

  // Last error source, error count and read data
  always_ff @(posedge clock or negedge sync2_ff)
  begin
    if (!sync2_ff)
    begin
      last_id_ff <= 3'h0;
      err_cnt_ff <= 8'h00;
      rdata_ff   <= 32'h0;
    end
    else
    begin
      last_id_ff <= |init_berr ? idx_of(init_berr) : last_id_ff;
      err_cnt_ff <= nxt_cnt;
      rdata_ff   <= reg_rd ? rd_mux : 32'h0;
    end
  end

  assign reg_rdata = rdata_ff;
  assign irq       = |(stat_ff & mask_ff);

  // ****************************************************************
  // Arbitration
  // ****************************************************************
  assign arb_mode              = cfg_ff[bmc_pkg::ARB_LSB +: 3];
  assign ram_wait_state_select = cfg_ff[bmc_pkg::WAIT_SEL_BIT];

  // Mode 0 fetch first, mode 1 rotates, mode 2 DMA first
  // Reserved codes fall back to mode 0 so the matrix never hangs
  assign arb_start =
    (arb_mode == bmc_pkg::ARB_MODE1) ? inc5(rr_last_ff)
  : (arb_mode == bmc_pkg::ARB_MODE2) ? 3'(bmc_pkg::INIT_DMA)
  : 3'(bmc_pkg::INIT_FETCH);

  assign gnt = pick(want, arb_start);

  // Remember the last winner for rotation
  always_ff @(posedge clock or negedge sync2_ff)
  begin
    if (!sync2_ff)
      rr_last_ff <= 3'h4;
    else
      rr_last_ff <= |gnt ? idx_of(gnt) : rr_last_ff;
  end

  // ****************************************************************
  // Initiator sequencers
  // ****************************************************************
  for (genvar g = 0; g < N; g++)
  begin : g_port
    bmc_port #(
      .IS_CPU (g == bmc_pkg::INIT_FETCH || g == bmc_pkg::INIT_DATA)
    ) u_port (
      .clock    (clock),
      .rst_b    (sync2_ff),
      .req      (init_req[g]),
      .unmapped (init_unmapped[g]),
      .ram_hit  (init_ram_hit[g]),
      .err_en   (err_en[g]),
      .dbg_mode (cpu_debug_mode),
      .wait_sel (ram_wait_state_select),
      .gnt      (gnt[g]),
      .want     (want[g]),
      .ack      (init_ack[g]),
      .berr     (init_berr[g]),
      .null_ack (init_null[g])
    );
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  pin_reset_a: assert property (
    @(posedge clock)
    !external_reset_pin_b |-> !dev_rst_b)
    else $error("pin low without device reset");

  shared_err_a: assert property (
    @(posedge clock) disable iff (!sync2_ff)
    init_berr[4] |-> $past(err_en[4]) && init_ack[4])
    else $error("shared bus error while disabled");

  debug_err_a: assert property (
    @(posedge clock) disable iff (!sync2_ff)
    init_berr[3] |-> $past(err_en[3]) && init_null[3])
    else $error("debug unit error while disabled");

  dma_quiet_a: assert property (
    @(posedge clock) disable iff (!sync2_ff)
    !err_en[2] && $stable(err_en) |=> !init_berr[2])
    else $error("DMA error while disabled");

  data_err_a: assert property (
    @(posedge clock) disable iff (!sync2_ff)
    init_berr[1] |-> !$past(cpu_debug_mode) && $past(err_en[1]))
    else $error("CPU data error in debug mode or disabled");

  fetch_dbg_a: assert property (
    @(posedge clock) disable iff (!sync2_ff)
    cpu_debug_mode |=> !init_berr[0])
    else $error("CPU fetch error in debug mode");

  grant_one_a: assert property (
    @(posedge clock) disable iff (!sync2_ff)
    $onehot0(gnt) && (|want == |gnt))
    else $error("arbiter grant not one-hot or lost");

  cfg_read_a: assert property (
    @(posedge clock) disable iff (!sync2_ff)
    reg_rd && sel_cfg |=> (reg_rdata & ~bmc_pkg::CFG_WMASK) == 32'h0)
    else $error("unimplemented config bits read nonzero");

endmodule // bmc_top
